// file: logic/cfcg_gate.sv
`timescale 1ns/1ns
module cfcg_gate
    import cfcg_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input cfcg_pkg::cfcg_est_t est_in,
    input cfcg_pkg::cfcg_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    output logic good_valid,
    output logic [7:0] good_confidence,
    output logic bad_pulse,
    output logic [7:0] current_confidence_threshold
);
    import cfcg_pkg::*;

    function automatic logic [7:0] sat_sub(input logic [7:0] a, input logic [7:0] b);
        sat_sub = (a > b) ? a - b : 8'h00;
    endfunction

    function automatic logic [7:0] sat_add(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] s;
        s = {1'b0, a} + {1'b0, b};
        sat_add = s[8] ? 8'hFF : s[7:0];
    endfunction

    // ------------------------------------------------------------
    // configuration and state
    // ------------------------------------------------------------
    logic use_predicted_sync_samples_r;
    logic [15:0] good_estimate_count_r;
    logic [15:0] bad_estimate_count_r;
    logic [7:0] abs_floor_r;
    logic [7:0] rel_floor_ofs_r;
    logic [7:0] dec_step_r;
    logic [9:0] bad_run_length_r;
    logic [7:0] abs_ceil_r;
    logic [7:0] rel_ceil_ofs_r;
    logic [7:0] inc_step_r;
    logic [9:0] good_run_length_r;
    logic [4:0] init_delay_r;
    logic [7:0] thr_r;
    logic [7:0] thr_nxt;
    logic [9:0] good_run_r;
    logic [9:0] good_run_nxt;
    logic [9:0] bad_run_r;
    logic [9:0] bad_run_nxt;
    logic [5:0] init_cnt_r;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic good_valid_r;
    logic [7:0] good_conf_r;
    logic bad_pulse_r;

    logic accept;
    logic in_init;
    logic is_good;
    logic [7:0] win_max;
    logic [7:0] low_bound;
    logic [7:0] high_bound;
    logic [7:0] stepped;

    // ------------------------------------------------------------
    // estimate qualification and classification
    // ------------------------------------------------------------
    assign accept = est_in.valid &&
        (est_in.sync_detected || (use_predicted_sync_samples_r && est_in.predicted));
    assign in_init = ({1'b0, init_cnt_r} <= {2'b00, init_delay_r});
    assign is_good = in_init || (est_in.confidence >= thr_r);

    cfcg_window_max cfcg_window_max_inst (
        .sys_clk(sys_clk),
        .rst(rst),
        .push(accept),
        .value(est_in.confidence),
        .max_value(win_max)
    );

    // ------------------------------------------------------------
    // threshold bounds and adaptation
    // ------------------------------------------------------------
    always_comb
    begin
        // a floor above the ceiling wins: the gate stays tight even if the loop goes dead
        low_bound = (abs_floor_r > sat_sub(win_max, rel_floor_ofs_r)) ?
            abs_floor_r : sat_sub(win_max, rel_floor_ofs_r);
        high_bound = (abs_ceil_r < sat_sub(win_max, rel_ceil_ofs_r)) ?
            abs_ceil_r : sat_sub(win_max, rel_ceil_ofs_r);
        good_run_nxt = good_run_r;
        bad_run_nxt = bad_run_r;
        stepped = thr_r;
        if (accept && !in_init)
        begin
            if (is_good)
            begin
                bad_run_nxt = 10'h000;
                if (good_run_r + 10'h001 >= good_run_length_r)
                begin
                    stepped = sat_add(thr_r, inc_step_r);
                    good_run_nxt = 10'h000;
                end
                else
                    good_run_nxt = good_run_r + 10'h001;
            end
            else
            begin
                good_run_nxt = 10'h000;
                if (bad_run_r + 10'h001 >= bad_run_length_r)
                begin
                    stepped = sat_sub(thr_r, dec_step_r);
                    bad_run_nxt = 10'h000;
                end
                else
                    bad_run_nxt = bad_run_r + 10'h001;
            end
        end
        if (stepped > high_bound)
            thr_nxt = high_bound;
        else
            thr_nxt = stepped;
        if (thr_nxt < low_bound)
            thr_nxt = low_bound;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            thr_r <= CFCG_RST_THRESHOLD;
            good_run_r <= 10'h000;
            bad_run_r <= 10'h000;
            init_cnt_r <= 6'h00;
        end
        else if (accept)
        begin
            thr_r <= thr_nxt;
            good_run_r <= good_run_nxt;
            bad_run_r <= bad_run_nxt;
            if (in_init)
                init_cnt_r <= init_cnt_r + 6'h01;
        end
    end

    // ------------------------------------------------------------
    // event counters and outputs to frequency control
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            good_estimate_count_r <= CFCG_RST_COUNT;
            bad_estimate_count_r <= CFCG_RST_COUNT;
            good_valid_r <= 1'b0;
            good_conf_r <= 8'h00;
            bad_pulse_r <= 1'b0;
        end
        else
        begin
            good_valid_r <= accept && is_good;
            bad_pulse_r <= accept && !is_good;
            if (accept && is_good)
            begin
                good_estimate_count_r <= good_estimate_count_r + 16'h0001;
                good_conf_r <= est_in.confidence;
            end
            if (accept && !is_good)
                bad_estimate_count_r <= bad_estimate_count_r + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // byte register port
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            use_predicted_sync_samples_r <= CFCG_RST_CTRL;
            abs_floor_r <= CFCG_RST_ABS_FLOOR;
            rel_floor_ofs_r <= CFCG_RST_REL_FLOOR_OFS;
            dec_step_r <= CFCG_RST_DEC_STEP;
            bad_run_length_r <= CFCG_RST_BAD_LEN;
            abs_ceil_r <= CFCG_RST_ABS_CEIL;
            rel_ceil_ofs_r <= CFCG_RST_REL_CEIL_OFS;
            inc_step_r <= CFCG_RST_INC_STEP;
            good_run_length_r <= CFCG_RST_GOOD_LEN;
            init_delay_r <= CFCG_RST_INIT_DELAY;
        end
        else if (reg_req.wr)
        begin
            case (reg_req.addr)
                CFCG_ADDR_CTRL: use_predicted_sync_samples_r <= reg_req.wdata[0];
                CFCG_ADDR_ABS_FLOOR: abs_floor_r <= reg_req.wdata;
                CFCG_ADDR_REL_FLOOR_OFS: rel_floor_ofs_r <= reg_req.wdata;
                CFCG_ADDR_DEC_STEP: dec_step_r <= reg_req.wdata;
                CFCG_ADDR_BAD_LEN_LO: bad_run_length_r[7:0] <= reg_req.wdata;
                CFCG_ADDR_BAD_LEN_HI: bad_run_length_r[9:8] <= reg_req.wdata[1:0];
                CFCG_ADDR_ABS_CEIL: abs_ceil_r <= reg_req.wdata;
                CFCG_ADDR_REL_CEIL_OFS: rel_ceil_ofs_r <= reg_req.wdata;
                CFCG_ADDR_INC_STEP: inc_step_r <= reg_req.wdata;
                CFCG_ADDR_GOOD_LEN_LO: good_run_length_r[7:0] <= reg_req.wdata;
                CFCG_ADDR_GOOD_LEN_HI: good_run_length_r[9:8] <= reg_req.wdata[1:0];
                CFCG_ADDR_INIT_DELAY: init_delay_r <= reg_req.wdata[4:0];
                default: ;
            endcase
        end
    end

    always_comb
    begin
        case (reg_req.addr)
            CFCG_ADDR_CTRL: rdata_nxt = {7'h00, use_predicted_sync_samples_r};
            CFCG_ADDR_GOOD_LO: rdata_nxt = good_estimate_count_r[7:0];
            CFCG_ADDR_GOOD_HI: rdata_nxt = good_estimate_count_r[15:8];
            CFCG_ADDR_BAD_LO: rdata_nxt = bad_estimate_count_r[7:0];
            CFCG_ADDR_BAD_HI: rdata_nxt = bad_estimate_count_r[15:8];
            CFCG_ADDR_ABS_FLOOR: rdata_nxt = abs_floor_r;
            CFCG_ADDR_REL_FLOOR_OFS: rdata_nxt = rel_floor_ofs_r;
            CFCG_ADDR_DEC_STEP: rdata_nxt = dec_step_r;
            CFCG_ADDR_BAD_LEN_LO: rdata_nxt = bad_run_length_r[7:0];
            CFCG_ADDR_BAD_LEN_HI: rdata_nxt = {6'h00, bad_run_length_r[9:8]};
            CFCG_ADDR_ABS_CEIL: rdata_nxt = abs_ceil_r;
            CFCG_ADDR_REL_CEIL_OFS: rdata_nxt = rel_ceil_ofs_r;
            CFCG_ADDR_INC_STEP: rdata_nxt = inc_step_r;
            CFCG_ADDR_GOOD_LEN_LO: rdata_nxt = good_run_length_r[7:0];
            CFCG_ADDR_GOOD_LEN_HI: rdata_nxt = {6'h00, good_run_length_r[9:8]};
            CFCG_ADDR_INIT_DELAY: rdata_nxt = {3'h0, init_delay_r};
            CFCG_ADDR_THRESHOLD: rdata_nxt = thr_r;
            default: rdata_nxt = 8'h00;
        endcase
    end

    // read data holds until the next read strobe
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            rdata_r <= 8'h00;
        else if (reg_req.rd)
            rdata_r <= rdata_nxt;
    end

    assign reg_rdata = rdata_r;
    assign good_valid = good_valid_r;
    assign good_confidence = good_conf_r;
    assign bad_pulse = bad_pulse_r;
    assign current_confidence_threshold = thr_r;

endmodule

// file: logic/cfcg_pkg.sv
package cfcg_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [15:0] CFCG_ADDR_CTRL = 16'h0708;
    localparam logic [15:0] CFCG_ADDR_GOOD_LO = 16'h0710;
    localparam logic [15:0] CFCG_ADDR_GOOD_HI = 16'h0711;
    localparam logic [15:0] CFCG_ADDR_BAD_LO = 16'h0715;
    localparam logic [15:0] CFCG_ADDR_BAD_HI = 16'h0716;
    localparam logic [15:0] CFCG_ADDR_ABS_FLOOR = 16'h0720;
    localparam logic [15:0] CFCG_ADDR_REL_FLOOR_OFS = 16'h0721;
    localparam logic [15:0] CFCG_ADDR_DEC_STEP = 16'h0722;
    localparam logic [15:0] CFCG_ADDR_BAD_LEN_LO = 16'h0723;
    localparam logic [15:0] CFCG_ADDR_BAD_LEN_HI = 16'h0724;
    localparam logic [15:0] CFCG_ADDR_ABS_CEIL = 16'h0726;
    localparam logic [15:0] CFCG_ADDR_REL_CEIL_OFS = 16'h0727;
    localparam logic [15:0] CFCG_ADDR_INC_STEP = 16'h0728;
    localparam logic [15:0] CFCG_ADDR_GOOD_LEN_LO = 16'h0729;
    localparam logic [15:0] CFCG_ADDR_GOOD_LEN_HI = 16'h072A;
    localparam logic [15:0] CFCG_ADDR_INIT_DELAY = 16'h072B;
    localparam logic [15:0] CFCG_ADDR_THRESHOLD = 16'h072D;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [0:0] CFCG_RST_CTRL = 1'h0;
    localparam logic [15:0] CFCG_RST_COUNT = 16'h0000;
    localparam logic [7:0] CFCG_RST_ABS_FLOOR = 8'h90;
    localparam logic [7:0] CFCG_RST_REL_FLOOR_OFS = 8'h08;
    localparam logic [7:0] CFCG_RST_DEC_STEP = 8'h01;
    localparam logic [9:0] CFCG_RST_BAD_LEN = 10'h020;
    localparam logic [7:0] CFCG_RST_ABS_CEIL = 8'hFF;
    localparam logic [7:0] CFCG_RST_REL_CEIL_OFS = 8'h06;
    localparam logic [7:0] CFCG_RST_INC_STEP = 8'h01;
    localparam logic [9:0] CFCG_RST_GOOD_LEN = 10'h001;
    localparam logic [4:0] CFCG_RST_INIT_DELAY = 5'h17;
    localparam logic [7:0] CFCG_RST_THRESHOLD = 8'h90;

    // ------------------------------------------------------------
    // sliding window
    // ------------------------------------------------------------
    localparam int CFCG_WIN_DEPTH = 8;
    localparam int CFCG_WIN_AW = 3;

    typedef struct packed {
        logic valid;
        logic sync_detected;
        logic predicted;
        logic [7:0] confidence;
    } cfcg_est_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] wdata;
    } cfcg_reg_req_t;

endpackage

// file: logic/cfcg_window_max.sv
`timescale 1ns/1ns
module cfcg_window_max
    import cfcg_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic push,
    input wire logic [7:0] value,
    output logic [7:0] max_value
);
    import cfcg_pkg::*;

    logic [7:0] win_r [CFCG_WIN_DEPTH];
    logic [CFCG_WIN_AW-1:0] wptr_r;

    // ------------------------------------------------------------
    // history store, oldest entry overwritten
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < CFCG_WIN_DEPTH; i++)
                win_r[i] <= 8'h00;
            wptr_r <= '0;
        end
        else if (push)
        begin
            win_r[wptr_r] <= value;
            wptr_r <= wptr_r + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // window maximum
    // ------------------------------------------------------------
    always_comb
    begin
        max_value = 8'h00;
        for (int i = 0; i < CFCG_WIN_DEPTH; i++)
            if (win_r[i] > max_value)
                max_value = win_r[i];
    end

endmodule

// file: tb/cfcg_freq_loop.sv
`timescale 1ns/1ns
module cfcg_freq_loop
    import cfcg_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic good_valid,
    input wire logic [7:0] good_confidence,
    output logic [15:0] taken,
    output logic [7:0] last_conf
);
    // loop sees only good estimates; bad ones never arrive
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            taken <= 16'h0000;
            last_conf <= 8'h00;
        end
        else if (good_valid)
        begin
            taken <= taken + 16'h0001;
            last_conf <= good_confidence;
        end
    end
endmodule

// file: tb/cfcg_gate_asserts.sv
`timescale 1ns/1ns
module cfcg_gate_chk
    import cfcg_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input cfcg_pkg::cfcg_est_t est_in,
    input cfcg_pkg::cfcg_reg_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic good_valid,
    input wire logic [7:0] good_confidence,
    input wire logic bad_pulse,
    input wire logic [7:0] current_confidence_threshold
);
    // ------------------------------------------------------------
    // shadows of control state
    // ------------------------------------------------------------
    logic ctl_r;
    logic [7:0] flr_r;
    logic [7:0] nacc_r;
    logic acc;
    logic [7:0] thr;
    assign thr = current_confidence_threshold;
    assign acc = est_in.valid && (est_in.sync_detected || (ctl_r && est_in.predicted));
    // init delay assumed left at reset value by the bench
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            ctl_r <= CFCG_RST_CTRL;
            flr_r <= CFCG_RST_ABS_FLOOR;
            nacc_r <= 8'h00;
        end
        else
        begin
            if (reg_req.wr && reg_req.addr == CFCG_ADDR_CTRL)
                ctl_r <= reg_req.wdata[0];
            if (reg_req.wr && reg_req.addr == CFCG_ADDR_ABS_FLOOR)
                flr_r <= reg_req.wdata;
            if (acc && nacc_r != 8'hFF)
                nacc_r <= nacc_r + 8'h01;
        end
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    property p_answer; acc |=> good_valid || bad_pulse; endproperty
    a_answer: assert property (p_answer) else $error("no verdict");
    property p_excl; !(good_valid && bad_pulse); endproperty
    a_excl: assert property (p_excl) else $error("both verdicts");
    property p_refuse; !acc |=> !good_valid && !bad_pulse; endproperty
    a_refuse: assert property (p_refuse) else $error("unqualified taken");
    property p_gconf; good_valid |-> good_confidence == $past(est_in.confidence); endproperty
    a_gconf: assert property (p_gconf) else $error("wrong confidence");
    property p_init; acc && nacc_r <= {3'h0, CFCG_RST_INIT_DELAY} |=> good_valid; endproperty
    a_init: assert property (p_init) else $error("init not good");
    property p_bad;
        acc && nacc_r > {3'h0, CFCG_RST_INIT_DELAY} && est_in.confidence < thr |=> bad_pulse;
    endproperty
    a_bad: assert property (p_bad) else $error("low not bad");
    property p_good;
        acc && nacc_r > {3'h0, CFCG_RST_INIT_DELAY} && est_in.confidence >= thr |=> good_valid;
    endproperty
    a_good: assert property (p_good) else $error("high not good");
    property p_floor; good_valid || bad_pulse |-> thr >= flr_r; endproperty
    a_floor: assert property (p_floor) else $error("below floor");
    property p_hold; !acc |=> $stable(thr); endproperty
    a_hold: assert property (p_hold) else $error("threshold moved");
    property p_rdthr; reg_req.rd && reg_req.addr == CFCG_ADDR_THRESHOLD |=> reg_rdata == $past(thr);
    endproperty
    a_rdthr: assert property (p_rdthr) else $error("threshold read");
    c_good: cover property (good_valid);
    c_bad: cover property (bad_pulse);
    c_refused: cover property (est_in.valid && !acc);
endmodule

// file: tb/coarse_freq_confidence_gate_bench.sv
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; \
    $display("unexpected t=%0t got %h exp %h", $time, a, b); end end
module coarse_freq_confidence_gate_bench;
    import cfcg_pkg::*;
    logic sys_clk = 0;
    logic rst = 1;
    cfcg_est_t est_in = '0;
    cfcg_reg_req_t reg_req = '0;
    logic [7:0] reg_rdata, good_confidence, current_confidence_threshold, er, last_conf;
    logic good_valid, bad_pulse, ctl = 0, rd_seen = 0;
    logic [15:0] taken, ng = 0, nb = 0;
    logic [17:0] ex;
    logic [17:0] qe[$];
    logic [7:0] qr[$];
    logic [7:0] thr = 8'h90, lastg = 8'h00, fl = 8'h90, fo = 8'h08, dc = 8'h01;
    logic [9:0] bl = 10'h020, br = 0;
    logic [7:0] win [8] = '{default: 8'h00};
    int checks = 0, n_mismatch = 0, nacc = 0;
    cfcg_gate cfcg_gate_inst (.sys_clk, .rst, .est_in, .reg_req, .reg_rdata, .good_valid,
        .good_confidence, .bad_pulse, .current_confidence_threshold);
    cfcg_freq_loop cfcg_freq_loop_inst (.sys_clk, .rst, .good_valid, .good_confidence,
        .taken, .last_conf);
    initial forever #10 sys_clk = ~sys_clk;
    // ------------------------------------------------------------
    // drivers and reference model
    // ------------------------------------------------------------
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge sys_clk);
        reg_req = '0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        qr.push_back(e);
        @(negedge sys_clk);
        reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge sys_clk);
        reg_req = '0;
    endtask
    task automatic step(input logic [7:0] c);
        logic [7:0] wm, lo, hi;
        logic g;
        wm = 8'h00;
        foreach (win[i]) wm = (win[i] > wm) ? win[i] : wm;
        lo = (wm > fo) ? wm - fo : 8'h00;
        lo = (fl > lo) ? fl : lo;
        hi = (wm > CFCG_RST_REL_CEIL_OFS) ? wm - CFCG_RST_REL_CEIL_OFS : 8'h00;
        g = (nacc <= CFCG_RST_INIT_DELAY) || (c >= thr);
        if (nacc > CFCG_RST_INIT_DELAY && g)
        begin
            br = 10'h000;
            thr = (thr > 8'hFF - CFCG_RST_INC_STEP) ? 8'hFF : thr + CFCG_RST_INC_STEP;
        end
        else if (nacc > CFCG_RST_INIT_DELAY)
        begin
            br++;
            if (br >= bl) thr = (thr > dc) ? thr - dc : 8'h00;
            if (br >= bl) br = 10'h000;
        end
        thr = (thr > hi) ? hi : thr;
        thr = (thr < lo) ? lo : thr;
        for (int i = 7; i > 0; i--) win[i] = win[i-1];
        win[0] = c;
        nacc++;
        if (g) lastg = c;
        if (g) ng++;
        else nb++;
        qe.push_back({g, !g, thr, lastg});
    endtask
    task automatic est(input logic [7:0] c, input logic [2:0] r);
        @(negedge sys_clk);
        est_in = '{valid: r[0], sync_detected: r[1], predicted: r[2], confidence: c};
        if (r[0] && (r[1] || (ctl && r[2]))) step(c);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // ------------------------------------------------------------
    // result monitor
    // ------------------------------------------------------------
    always @(posedge sys_clk) rd_seen <= reg_req.rd;
    always @(negedge sys_clk)
    begin
        // an unknown verdict must not slip past unchecked
        if (good_valid !== 1'b0 || bad_pulse !== 1'b0)
        begin
            ex = qe.pop_front();
            `CHK({good_valid, bad_pulse, current_confidence_threshold, good_confidence}, ex)
        end
        if (rd_seen)
        begin
            er = qr.pop_front();
            `CHK(reg_rdata, er)
        end
    end
    initial
    begin
        #400000;
        n_mismatch++;
        test_done;
    end
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial
    begin
        void'($urandom(82));
        repeat (4) @(negedge sys_clk);
        rst = 0;
        wr(CFCG_ADDR_GOOD_LO, 8'hFF);
        rd(CFCG_ADDR_CTRL, 8'h00);
        rd(CFCG_ADDR_GOOD_LO, 8'h00);
        rd(CFCG_ADDR_GOOD_HI, 8'h00);
        rd(CFCG_ADDR_BAD_LO, 8'h00);
        rd(CFCG_ADDR_BAD_HI, 8'h00);
        rd(CFCG_ADDR_ABS_FLOOR, CFCG_RST_ABS_FLOOR);
        rd(CFCG_ADDR_REL_FLOOR_OFS, CFCG_RST_REL_FLOOR_OFS);
        rd(CFCG_ADDR_DEC_STEP, CFCG_RST_DEC_STEP);
        rd(CFCG_ADDR_BAD_LEN_LO, CFCG_RST_BAD_LEN[7:0]);
        rd(CFCG_ADDR_BAD_LEN_HI, {6'h00, CFCG_RST_BAD_LEN[9:8]});
        // the model below leans on these reset values, so confirm them first
        rd(CFCG_ADDR_ABS_CEIL, CFCG_RST_ABS_CEIL);
        rd(CFCG_ADDR_REL_CEIL_OFS, CFCG_RST_REL_CEIL_OFS);
        rd(CFCG_ADDR_INC_STEP, CFCG_RST_INC_STEP);
        rd(CFCG_ADDR_GOOD_LEN_LO, CFCG_RST_GOOD_LEN[7:0]);
        rd(CFCG_ADDR_INIT_DELAY, {3'h0, CFCG_RST_INIT_DELAY});
        rd(CFCG_ADDR_THRESHOLD, CFCG_RST_THRESHOLD);
        rd(16'h0700, 8'h00);
        $display("reset values done");
        fl = 8'h60 + 8'($urandom % 32);
        fo = 8'($urandom % 16);
        dc = 8'(1 + $urandom % 6);
        bl = 10'(1 + $urandom % 4);
        wr(CFCG_ADDR_ABS_FLOOR, fl);
        wr(CFCG_ADDR_REL_FLOOR_OFS, fo);
        wr(CFCG_ADDR_DEC_STEP, dc);
        wr(CFCG_ADDR_BAD_LEN_LO, bl[7:0]);
        wr(CFCG_ADDR_BAD_LEN_HI, 8'hFC);
        rd(CFCG_ADDR_ABS_FLOOR, fl);
        rd(CFCG_ADDR_REL_FLOOR_OFS, fo);
        rd(CFCG_ADDR_DEC_STEP, dc);
        rd(CFCG_ADDR_BAD_LEN_LO, bl[7:0]);
        rd(CFCG_ADDR_BAD_LEN_HI, 8'h00);
        $display("config done");
        repeat (6)
        begin
            ctl = 1'($urandom);
            wr(CFCG_ADDR_CTRL, {7'h00, ctl});
            rd(CFCG_ADDR_CTRL, {7'h00, ctl});
            repeat (60) est(8'h80 + 8'($urandom % 64), 3'($urandom));
            est(8'h00, 3'h0);
            rd(CFCG_ADDR_THRESHOLD, thr);
        end
        $display("estimates done");
        rd(CFCG_ADDR_GOOD_LO, ng[7:0]);
        rd(CFCG_ADDR_GOOD_HI, ng[15:8]);
        rd(CFCG_ADDR_BAD_LO, nb[7:0]);
        rd(CFCG_ADDR_BAD_HI, nb[15:8]);
        repeat (2) @(negedge sys_clk);
        `CHK(taken, ng)
        `CHK(last_conf, lastg)
        `CHK(qe.size() + qr.size(), 0)
        $display("counters done");
        test_done;
    end
endmodule
bind cfcg_gate cfcg_gate_chk cfcg_gate_chk_inst (.sys_clk, .rst, .est_in, .reg_req, .reg_rdata,
    .good_valid, .good_confidence, .bad_pulse, .current_confidence_threshold);
